// *** verilog/ucc_map.vh ***
`ifndef UCC_MAP_VH
`define UCC_MAP_VH
// Register indices on the plain port
`define UCC_ADDR_W 3
`define UCC_REG_FIFO_CONTROL 3'h2
`define UCC_REG_INT_STATUS 3'h2
`define UCC_REG_LINE_CONTROL 3'h3
`define UCC_REG_MODEM_CONTROL 3'h4
`define UCC_REG_CHAN_STATUS 3'h5
`define UCC_REG_EVENTS 3'h6
// fifo_control fields
`define UCC_FC_ENABLE 0
`define UCC_FC_RX_RESET 1
`define UCC_FC_TX_RESET 2
`define UCC_FC_MODE 3
`define UCC_FC_TX_TRIG_LO 4
`define UCC_FC_RX_TRIG_LO 6
// line_control fields, then modem_control and enhanced feature bits
`define UCC_LC_STOP 2
`define UCC_LC_PAR_EN 3
`define UCC_LC_PAR_EVEN 4
`define UCC_LC_PAR_FORCE 5
`define UCC_LC_BREAK 6
`define UCC_LC_DIV_ACCESS 7
`define UCC_MC_DTR 0
`define UCC_EF_ENH 4
// Reset values
`define UCC_FC_RESET 8'h00
`define UCC_LC_RESET 8'h00
`define UCC_MC_RESET 8'h00
// Interrupt codes, bits 5..0
`define UCC_ISR_NONE 6'h01
`define UCC_ISR_LINE 6'h06
`define UCC_ISR_RXDATA 6'h04
`define UCC_ISR_RXTIMEOUT 6'h0C
`define UCC_ISR_TXEMPTY 6'h02
`define UCC_ISR_MODEM 6'h00
`define UCC_ISR_XOFF 6'h10
`define UCC_ISR_FLOW 6'h20
// Timeout: four character times in bit times
`define UCC_TIMEOUT_CHARS 4
// Bit times in one character slot, start to stop
`define UCC_CHAR_BITS 12
// Transmit trigger levels by field value
`define UCC_TX_TRIG_0 8'h08
`define UCC_TX_TRIG_1 8'h10
`define UCC_TX_TRIG_2 8'h20
`define UCC_TX_TRIG_3 8'h38
// Receive trigger levels by field value
`define UCC_RX_TRIG_0 8'h08
`define UCC_RX_TRIG_1 8'h10
`define UCC_RX_TRIG_2 8'h38
`define UCC_RX_TRIG_3 8'h3C
`endif

// *** verilog/ucc_channel_control.v ***
// What this block does
// - Mode 0 transmit-ready low when transmit side empty
// - Mode 0 receive-ready low while data held
// - Mode 1 transmit-ready high only when full
// - Mode 1 receive-ready low on trigger/timeout
// - Transmit trigger 8/16/32/56, interrupt below level
// - Receive trigger 8/16/56/60, interrupt at level
// - Status read shows highest pending source only
// - Status read clears only reported source
// - Seven priority levels with fixed codes
// - Bit 0 low while pending, high otherwise
// - Bits 4,5 need enhanced bit; Xoff sticky
// - Bits 6,7 mirror FIFO enable
// - Word length 5..8 from field, default 5
// - Stop bits one, one and a half, or two
// - Parity enable adds and checks parity
// - Parity type odd when 0, even when 1
// - Forced parity is inverse of type bit
// - Break holds serial output low
// - Bit 7 redirects to divisor and enhanced
// - Modem bit 0 drives terminal-ready low
//
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`include "ucc_map.vh"
module ucc_channel_control #(
    parameter FIFO_DEPTH = 64,
    parameter CNT_W = 7,
    parameter BIT_CYCLES = 16
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Register port
    input wire [2:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    output reg [7:0] rdata,
    // Enhanced feature register bit 4 from the special register set
    input wire enh_enable,
    // FIFO and transmitter state from the data path
    input wire [CNT_W-1:0] tx_count,
    input wire tx_shift_busy,
    input wire [CNT_W-1:0] rx_count,
    input wire rx_char_in,
    input wire rx_data_read,
    // Interrupt sources
    input wire line_status_event,
    input wire modem_status_event,
    input wire xoff_event,
    input wire xon_event,
    input wire flow_event,
    // Serial side
    input wire tx_serial_raw,
    output reg tx_serial,
    output reg tx_ready_n,
    output reg rx_ready_n,
    output reg dtr_n,
    // Format and control to the data path
    output reg [3:0] data_bits,
    output reg [1:0] stop_halves,
    output reg parity_on,
    output reg parity_forced,
    output reg parity_value_even,
    output reg divisor_access,
    output reg fifo_enabled,
    output reg dma_mode,
    output reg rx_fifo_clear,
    output reg tx_fifo_clear,
    output reg int_pending
);

reg [7:0] line_control;
reg [7:0] modem_control;
reg [5:0] fifo_cfg;
reg [7:0] tx_level;
reg [7:0] rx_level;
// Pending sources, one flag per priority level except received data, which comes from the count
reg p_line;
reg p_rxto;
reg p_tx;
reg p_modem;
reg p_xoff;
reg p_flow;
reg xoff_held;
reg rx_mode1_active;
reg [15:0] to_cnt;
reg [5:0] cur_code;
reg [5:0] next_code;
reg [CNT_W-1:0] tx_count_q;

// Timeout length: bit time, times bits per character, times four characters
localparam integer TO_FULL = BIT_CYCLES * `UCC_CHAR_BITS * `UCC_TIMEOUT_CHARS;
localparam [15:0] TO_CYCLES = TO_FULL[15:0];

// The two directions use different tables; receive reaches nearly full
function [7:0] tx_trig;
    input [1:0] sel;
    begin
        case (sel)
            2'h0: tx_trig = `UCC_TX_TRIG_0;
            2'h1: tx_trig = `UCC_TX_TRIG_1;
            2'h2: tx_trig = `UCC_TX_TRIG_2;
            default: tx_trig = `UCC_TX_TRIG_3;
        endcase
    end
endfunction

function [7:0] rx_trig;
    input [1:0] sel;
    begin
        case (sel)
            2'h0: rx_trig = `UCC_RX_TRIG_0;
            2'h1: rx_trig = `UCC_RX_TRIG_1;
            2'h2: rx_trig = `UCC_RX_TRIG_2;
            default: rx_trig = `UCC_RX_TRIG_3;
        endcase
    end
endfunction

// Index match; a hidden slot answers to nothing while divisor access is set
function reg_hit;
    input [2:0] a;
    input [2:0] idx;
    input hidden;
    begin
        reg_hit = (a == idx) && !hidden;
    end
endfunction

// Block transfer mode needs both the enable and the mode bit
function block_mode;
    input [5:0] cfg;
    begin
        block_mode = cfg[0] & cfg[1];
    end
endfunction

wire div_on = line_control[`UCC_LC_DIV_ACCESS];
wire isr_read = rd && reg_hit(addr, `UCC_REG_INT_STATUS, div_on);
wire fc_write = wr && reg_hit(addr, `UCC_REG_FIFO_CONTROL, div_on);
wire lc_write = wr && reg_hit(addr, `UCC_REG_LINE_CONTROL, 1'b0);
wire mc_write = wr && reg_hit(addr, `UCC_REG_MODEM_CONTROL, 1'b0);
wire [7:0] tx_cnt8 = {{(8-CNT_W){1'b0}}, tx_count};
wire [7:0] rx_cnt8 = {{(8-CNT_W){1'b0}}, rx_count};
wire rx_at_trig = fifo_enabled ? (rx_cnt8 >= rx_level) : (rx_count != 0);
wire tx_below = fifo_enabled ? (tx_cnt8 < tx_level) : (tx_count == 0);
wire [CNT_W:0] depth_w = FIFO_DEPTH[CNT_W:0];
wire tx_full = ({1'b0, tx_count} >= depth_w);
// Tracks whether the transmit count just fell, so the empty event fires once
wire tx_count_fell = (tx_count < tx_count_q) || (!fifo_enabled && tx_count == 0
    && tx_count_q != 0);
// Timeout only meaningful with data below the trigger level
wire to_armed = fifo_enabled && (rx_count != 0) && !rx_at_trig;

// Priority encoder: only one source is ever presented
always @*
begin
    if (p_line)
        next_code = `UCC_ISR_LINE;
    else if (rx_at_trig)
        next_code = `UCC_ISR_RXDATA;
    else if (p_rxto)
        next_code = `UCC_ISR_RXTIMEOUT;
    else if (p_tx)
        next_code = `UCC_ISR_TXEMPTY;
    else if (p_modem)
        next_code = `UCC_ISR_MODEM;
    else if (p_xoff && enh_enable)
        next_code = `UCC_ISR_XOFF;
    else if (p_flow && enh_enable)
        next_code = `UCC_ISR_FLOW;
    else
        next_code = `UCC_ISR_NONE;
end

always @(posedge clk)
begin
    if (!rst_n)
    begin
        line_control <= `UCC_LC_RESET;
        modem_control <= `UCC_MC_RESET;
        fifo_cfg <= 6'h00;
        rx_fifo_clear <= 1'b0;
        tx_fifo_clear <= 1'b0;
        tx_level <= `UCC_TX_TRIG_0;
        rx_level <= `UCC_RX_TRIG_0;
        p_line <= 1'b0;
        p_rxto <= 1'b0;
        p_tx <= 1'b0;
        p_modem <= 1'b0;
        p_xoff <= 1'b0;
        p_flow <= 1'b0;
        xoff_held <= 1'b0;
        to_cnt <= 16'h0000;
        cur_code <= `UCC_ISR_NONE;
    end
    else
    begin
        rx_fifo_clear <= 1'b0;
        tx_fifo_clear <= 1'b0;
        if (lc_write)
            line_control <= wdata;
        if (mc_write)
            modem_control <= wdata;
        if (fc_write)
        begin
            // Other fields land only alongside the enable bit
            if (wdata[`UCC_FC_ENABLE])
            begin
                fifo_cfg <= {wdata[7:4], wdata[`UCC_FC_MODE], 1'b1};
                tx_level <= tx_trig(wdata[`UCC_FC_TX_TRIG_LO +: 2]);
                rx_level <= rx_trig(wdata[`UCC_FC_RX_TRIG_LO +: 2]);
                // Clear strobes last one cycle; the data path drops its counts on them
                rx_fifo_clear <= wdata[`UCC_FC_RX_RESET];
                tx_fifo_clear <= wdata[`UCC_FC_TX_RESET];
            end
            else
                fifo_cfg[0] <= 1'b0;
        end
        // Timeout counter restarts on every arrival or data read
        if (!to_armed || rx_char_in || rx_data_read)
            to_cnt <= 16'h0000;
        else if (to_cnt != TO_CYCLES)
            to_cnt <= to_cnt + 16'h0001;
        // Sources: a new event beats the clear of the same cycle, except transmit empty, which sets only when not pending
        if (line_status_event)
            p_line <= 1'b1;
        else if (isr_read && cur_code == `UCC_ISR_LINE)
            p_line <= 1'b0;
        // Timeout falls away by itself once data is read or the trigger is met
        if (to_armed && to_cnt == TO_CYCLES - 16'h0001)
            p_rxto <= 1'b1;
        else if (rx_data_read || !to_armed)
            p_rxto <= 1'b0;
        if (tx_below && !p_tx && tx_count_fell)
            p_tx <= 1'b1;
        else if (isr_read && cur_code == `UCC_ISR_TXEMPTY)
            p_tx <= 1'b0;
        else if (!tx_below)
            p_tx <= 1'b0;
        if (modem_status_event)
            p_modem <= 1'b1;
        else if (isr_read && cur_code == `UCC_ISR_MODEM)
            p_modem <= 1'b0;
        if (xoff_event)
            xoff_held <= 1'b1;
        else if (xon_event)
            xoff_held <= 1'b0;
        if (xoff_event)
            p_xoff <= 1'b1;
        else if (xon_event)
            p_xoff <= 1'b0;
        if (flow_event)
            p_flow <= 1'b1;
        else if (isr_read && cur_code == `UCC_ISR_FLOW)
            p_flow <= 1'b0;
        cur_code <= next_code;
    end
end

// Read data stand only in the cycle after the strobe, zero otherwise
always @(posedge clk)
begin
    if (!rst_n)
        rdata <= 8'h00;
    else
    begin
        rdata <= 8'h00;
        if (rd)
        begin
            case (addr)
                `UCC_REG_INT_STATUS:
                begin
                    // Hidden behind divisor access, like the clear that goes with it
                    if (!div_on)
                        rdata <= {{2{fifo_enabled}}, cur_code};
                end
                `UCC_REG_LINE_CONTROL:
                    rdata <= line_control;
                `UCC_REG_MODEM_CONTROL:
                    rdata <= modem_control;
                `UCC_REG_CHAN_STATUS:
                    rdata <= {2'h0, xoff_held, tx_full, fifo_cfg[1], fifo_enabled,
                        rx_ready_n, tx_ready_n};
                `UCC_REG_EVENTS:
                    // Pending flags for polling; this read clears none of them
                    rdata <= {2'h0, p_flow, p_xoff, p_modem, p_tx, p_rxto, p_line};
                default:
                    rdata <= 8'h00;
            endcase
        end
    end
end

// Previous transmit count for the falling-edge test above
always @(posedge clk)
begin
    if (!rst_n)
        tx_count_q <= {CNT_W{1'b0}};
    else
        tx_count_q <= tx_count;
end

// Mode 1 receive-ready latches until the FIFO drains
always @(posedge clk)
begin
    if (!rst_n)
        rx_mode1_active <= 1'b0;
    else if (rx_at_trig || p_rxto)
        rx_mode1_active <= 1'b1;
    else if (rx_count == 0)
        rx_mode1_active <= 1'b0;
end

// Registered outputs
always @(posedge clk)
begin
    if (!rst_n)
    begin
        tx_ready_n <= 1'b0;
        rx_ready_n <= 1'b1;
        dtr_n <= 1'b1;
        tx_serial <= 1'b1;
        data_bits <= 4'h5;
        stop_halves <= 2'h2;
        parity_on <= 1'b0;
        parity_forced <= 1'b0;
        parity_value_even <= 1'b0;
        divisor_access <= 1'b0;
        fifo_enabled <= 1'b0;
        dma_mode <= 1'b0;
        int_pending <= 1'b0;
    end
    else
    begin
        fifo_enabled <= fifo_cfg[0];
        dma_mode <= block_mode(fifo_cfg);
        if (block_mode(fifo_cfg))
        begin
            // Block mode: transmit-ready only marks a full FIFO
            tx_ready_n <= tx_full;
            rx_ready_n <= !(rx_mode1_active || rx_at_trig || p_rxto);
        end
        else
        begin
            // Single mode ignores the trigger; any held character counts
            tx_ready_n <= (tx_count != 0) || tx_shift_busy;
            rx_ready_n <= (rx_count == 0);
        end
        dtr_n <= !modem_control[`UCC_MC_DTR];
        // Break forces the line low without disturbing the transmitter behind it
        tx_serial <= line_control[`UCC_LC_BREAK] ? 1'b0 : tx_serial_raw;
        data_bits <= 4'h5 + {2'h0, line_control[1:0]};
        // Half bit times modulo four: 2 is one, 3 one and a half, 0 two
        if (!line_control[`UCC_LC_STOP])
            stop_halves <= 2'h2;
        else if (line_control[1:0] == 2'h0)
            stop_halves <= 2'h3;
        else
            stop_halves <= 2'h0;
        parity_on <= line_control[`UCC_LC_PAR_EN];
        parity_forced <= line_control[`UCC_LC_PAR_EN] & line_control[`UCC_LC_PAR_FORCE];
        // Forced: 1 when type is 0; otherwise type selects even
        parity_value_even <= line_control[`UCC_LC_PAR_FORCE] ?
            !line_control[`UCC_LC_PAR_EVEN] : line_control[`UCC_LC_PAR_EVEN];
        divisor_access <= line_control[`UCC_LC_DIV_ACCESS];
        // Same encoder and same edge as the status code, so both always agree
        int_pending <= (next_code != `UCC_ISR_NONE);
    end
end

endmodule

// *** verification/ucc_checker.sv ***
`timescale 1ns/1ps
module ucc_checker #(
    parameter FIFO_DEPTH = 64,
    parameter CNT_W = 7
) (
    // Clock, reset and register port
    input wire clk,
    input wire rst_n,
    input wire [2:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    input wire [7:0] rdata,
    // Data path state
    input wire [CNT_W-1:0] tx_count,
    input wire [CNT_W-1:0] rx_count,
    // Block outputs
    input wire tx_serial,
    input wire tx_ready_n,
    input wire rx_ready_n,
    input wire dtr_n,
    input wire [3:0] data_bits,
    input wire [1:0] stop_halves,
    input wire parity_on,
    input wire divisor_access,
    input wire fifo_enabled,
    input wire dma_mode
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    wire lcw = wr && addr == 3'h3;
    wire blk = fifo_enabled && dma_mode;
    a_word_len: assert property (lcw |-> ##2 data_bits == 4'h5 + $past(wdata[1:0], 2))
        else $error("word length wrong");
    a_stop_len: assert property (lcw |-> ##2 stop_halves == (!$past(wdata[2], 2) ? 2'h2 :
        ($past(wdata[1:0], 2) == 2'h0 ? 2'h3 : 2'h0)))
        else $error("stop length wrong");
    a_parity_on: assert property (lcw |-> ##2 parity_on == $past(wdata[3], 2))
        else $error("parity enable wrong");
    a_break_low: assert property (lcw && wdata[6] |-> ##2 !tx_serial)
        else $error("break not driven");
    a_div_access: assert property (lcw |-> ##2 divisor_access == $past(wdata[7], 2))
        else $error("divisor access wrong");
    a_dtr_level: assert property (wr && addr == 3'h4 |-> ##2 dtr_n == !$past(wdata[0], 2))
        else $error("terminal ready wrong");
    a_tx_full: assert property (blk |-> tx_ready_n == ($past(tx_count) == FIFO_DEPTH))
        else $error("block mode tx ready wrong");
    a_rx_held: assert property (!blk |-> rx_ready_n == ($past(rx_count) == 0))
        else $error("single mode rx ready wrong");
    a_fifo_bits: assert property (rd && addr == 3'h2 ##1 !divisor_access |->
        rdata[7:6] == {2{$past(fifo_enabled)}})
        else $error("status top bits wrong");
    c_break: cover property (lcw && wdata[6]);
    c_full: cover property (blk && tx_ready_n);
    c_pend: cover property (rd && addr == 3'h2 ##1 !rdata[0]);
endmodule
bind ucc_channel_control ucc_checker #(.FIFO_DEPTH(FIFO_DEPTH), .CNT_W(CNT_W)) u_chk (
    .clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata, .tx_count, .rx_count, .tx_serial,
    .tx_ready_n, .rx_ready_n, .dtr_n, .data_bits, .stop_halves, .parity_on,
    .divisor_access, .fifo_enabled, .dma_mode);

// *** verification/ucc_path_model.sv ***
`timescale 1ns/1ps
module ucc_path_model (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Requests from the bench
    input wire [6:0] tx_lvl,
    input wire [6:0] rx_lvl,
    input wire [4:0] ev,
    // Data path state towards the block
    output reg [6:0] tx_count = 7'h00,
    output reg [6:0] rx_count = 7'h00,
    output reg tx_busy = 1'b0,
    output reg rx_in = 1'b0,
    output reg rx_rd = 1'b0,
    output reg [4:0] ev_q = 5'h00,
    output reg raw = 1'b1
);
    // Raw bit flips every cycle so a stuck or leaking break shows at once
    always @(posedge clk)
    begin
        raw <= rst_n ? ~raw : 1'b1;
        tx_count <= tx_lvl;
        rx_count <= rx_lvl;
        tx_busy <= tx_count != 7'h00;
        rx_in <= rx_lvl > rx_count;
        rx_rd <= rx_lvl < rx_count;
        ev_q <= ev;
    end
endmodule

// *** verification/tb_uart_channel_control.sv ***
`timescale 1ns/1ps
module tb_uart_channel_control;
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg [2:0] addr = 3'h0;
    reg [7:0] wdata = 8'h00;
    reg wr = 1'b0;
    reg rd = 1'b0;
    reg enh = 1'b0;
    reg [6:0] tx_lvl = 7'h00;
    reg [6:0] rx_lvl = 7'h00;
    reg [4:0] ev = 5'h00;
    wire [6:0] txc, rxc;
    wire [4:0] evq;
    wire [7:0] rdata;
    wire [3:0] dbits;
    wire [1:0] stops;
    wire busy, rxin, rxrd, raw, txs, txr_n, rxr_n, dtr_n, pon, pfrc, pev, div, fen, dma;
    wire intp, rxclr, txclr;
    integer clr_cnt = 0;
    integer err_total = 0;
    integer num_checks = 0;
    integer i;
    reg [7:0] v;
    ucc_path_model PM (.clk(clk), .rst_n(rst_n), .tx_lvl(tx_lvl), .rx_lvl(rx_lvl), .ev(ev),
        .tx_count(txc), .rx_count(rxc), .tx_busy(busy), .rx_in(rxin), .rx_rd(rxrd),
        .ev_q(evq), .raw(raw));
    ucc_channel_control #(.BIT_CYCLES(2)) DUT (.clk(clk), .rst_n(rst_n), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .enh_enable(enh), .tx_count(txc),
        .tx_shift_busy(busy), .rx_count(rxc), .rx_char_in(rxin), .rx_data_read(rxrd),
        .line_status_event(evq[0]), .modem_status_event(evq[1]), .xoff_event(evq[2]),
        .xon_event(evq[3]), .flow_event(evq[4]), .tx_serial_raw(raw), .tx_serial(txs),
        .tx_ready_n(txr_n), .rx_ready_n(rxr_n), .dtr_n(dtr_n), .data_bits(dbits),
        .stop_halves(stops), .parity_on(pon), .parity_forced(pfrc),
        .parity_value_even(pev), .divisor_access(div), .fifo_enabled(fen),
        .dma_mode(dma), .rx_fifo_clear(rxclr), .tx_fifo_clear(txclr), .int_pending(intp));
    // Counts clear strobes so a missing or extra one shows up
    always @(posedge clk)
    begin
        clr_cnt <= clr_cnt + rxclr + txclr;
    end
    initial
    begin
        forever #5 clk = ~clk;
    end
    task wrap_up;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input [8*6:1] n, input [7:0] e, input [7:0] g);
        num_checks = num_checks + 1;
        if (g !== e)
        begin
            err_total = err_total + 1;
            $display("ERROR %0s exp %h got %h", n, e, g);
        end
    endtask
    // Idle gap lets derived outputs and the latched status code settle
    task wreg(input [2:0] a, input [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task rreg(input [2:0] a);
        repeat (3) @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task rchk(input [2:0] a, input [7:0] e);
        rreg(a);
        chk("read", e, v);
    endtask
    task lvl(input [6:0] t, input [6:0] r);
        @(posedge clk);
        tx_lvl <= t;
        rx_lvl <= r;
        repeat (4) @(posedge clk);
        #1;
    endtask
    task pulse(input [4:0] e);
        @(posedge clk);
        ev <= e;
        @(posedge clk);
        ev <= 5'h00;
    endtask
    initial
    begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rchk(3'h2, 8'h01);
        rchk(3'h3, 8'h00);
        rchk(3'h4, 8'h00);
        chk("dtr", 8'h01, dtr_n);
        lvl(7'h01, 7'h01);
        chk("tx_ready_n", 8'h01, txr_n);
        chk("rx_ready_n", 8'h00, rxr_n);
        lvl(7'h00, 7'h00);
        chk("tx_ready_n", 8'h00, txr_n);
        chk("rx_ready_n", 8'h01, rxr_n);
        for (i = 0; i < 4; i = i + 1)
        begin
            wreg(3'h3, 8'h04 | i);
            chk("bits", 8'h05 + i, dbits);
            chk("stops", (i == 0) ? 8'h03 : 8'h00, stops);
            wreg(3'h3, 8'h08 | (i << 4));
            chk("par", 8'h01, pon);
            chk("force", i >> 1, pfrc);
            chk("even", i[0] ^ i[1], pev);
        end
        rchk(3'h3, 8'h38);
        wreg(3'h3, 8'h40);
        for (i = 0; i < 4; i = i + 1)
        begin
            @(posedge clk);
            #1 chk("txs", 8'h00, txs);
        end
        wreg(3'h3, 8'h80);
        chk("stops", 8'h02, stops);
        chk("par", 8'h00, pon);
        chk("txs", !raw, txs);
        chk("div", 8'h01, div);
        wreg(3'h3, 8'h00);
        chk("div", 8'h00, div);
        wreg(3'h4, 8'h01);
        chk("dtr", 8'h00, dtr_n);
        rchk(3'h4, 8'h01);
        rchk(3'h7, 8'h00);
        wreg(3'h2, 8'h0F);
        chk("clr", 8'h02, clr_cnt);
        lvl(7'h40, 7'h00);
        chk("tx_ready_n", 8'h01, txr_n);
        lvl(7'h3F, 7'h00);
        chk("tx_ready_n", 8'h00, txr_n);
        wreg(3'h2, 8'h06);
        chk("fen", 8'h00, fen);
        chk("dma", 8'h00, dma);
        chk("clr", 8'h02, clr_cnt);
        rchk(3'h5, 8'h0B);
        wreg(3'h2, 8'h49);
        lvl(7'h3F, 7'h0F);
        chk("rx_ready_n", 8'h01, rxr_n);
        lvl(7'h3F, 7'h10);
        chk("rx_ready_n", 8'h00, rxr_n);
        rchk(3'h2, 8'hC4);
        lvl(7'h3F, 7'h01);
        chk("rx_ready_n", 8'h00, rxr_n);
        lvl(7'h3F, 7'h00);
        chk("rx_ready_n", 8'h01, rxr_n);
        lvl(7'h3F, 7'h05);
        chk("rx_ready_n", 8'h01, rxr_n);
        repeat (100) @(posedge clk);
        #1;
        chk("rx_ready_n", 8'h00, rxr_n);
        rchk(3'h2, 8'hCC);
        lvl(7'h3F, 7'h04);
        rchk(3'h2, 8'hC1);
        lvl(7'h3F, 7'h00);
        chk("rx_ready_n", 8'h01, rxr_n);
        wreg(3'h2, 8'h21);
        lvl(7'h28, 7'h00);
        rreg(3'h2);
        lvl(7'h20, 7'h00);
        rchk(3'h2, 8'hC1);
        lvl(7'h1F, 7'h00);
        rchk(3'h2, 8'hC2);
        rchk(3'h2, 8'hC1);
        pulse(5'h03);
        rchk(3'h2, 8'hC6);
        chk("int", 8'h01, intp);
        rchk(3'h2, 8'hC0);
        rchk(3'h2, 8'hC1);
        chk("int", 8'h00, intp);
        pulse(5'h04);
        rchk(3'h2, 8'hC1);
        @(posedge clk);
        enh <= 1'b1;
        pulse(5'h04);
        rchk(3'h2, 8'hD0);
        rchk(3'h2, 8'hD0);
        pulse(5'h08);
        rchk(3'h2, 8'hC1);
        pulse(5'h10);
        rchk(3'h2, 8'hE0);
        wrap_up;
    end
    initial
    begin
        #100000;
        err_total = err_total + 1;
        wrap_up;
    end
endmodule
